// *** hdl/cdsp_port.sv ***
// cdsp_port: processor side port of a 16-bit cache data ram
// assumes plain asynchronous static rams wired straight to the pins
// assumes the hit logic outside holds a request until o_req_ready
`timescale 1ns/1ps
module cdsp_port
	import cdsp_pkg::*;
#(
	parameter int ADDR_W = CDSP_ADDR_W,
	parameter int DATA_W = CDSP_DATA_W
) (
	input wire logic i_clk, // 10 MHz system clock
	input wire logic i_reset_n, // async reset, active low
	input wire cdsp_req_t i_req, // access request
	input wire logic i_req_valid, // request present
	output logic o_req_ready, // request taken this edge
	output logic [DATA_W-1:0] o_rdata, // last read data
	output logic o_rdata_valid, // read data updated, pulse
	output logic [ADDR_W-1:0] o_cache_word_addr, // ram address
	output logic o_upper_lane_select_n, // upper byte ram select
	output logic o_lower_lane_select_n, // lower byte ram select
	output logic o_ram_write_strobe_n, // ram write enable
	output logic o_ram_output_enable_n, // ram output enable
	output logic [DATA_W-1:0] o_cache_data_bus, // data bus output
	output logic o_cache_data_bus_oe, // data bus drive enable
	input wire logic [DATA_W-1:0] i_cache_data_bus, // data bus input
	output logic o_copro_addr2 // address bit 2 to coprocessor
);
	typedef enum logic [1:0] {
		CDSP_ST_IDLE,
		CDSP_ST_SETUP,
		CDSP_ST_STROBE
	} cdsp_state_t;

	cdsp_state_t state_r;
	cdsp_state_t state_nxt;
	cdsp_pins_t pins_r;
	cdsp_pins_t pins_nxt;
	cdsp_op_t op_r;
	cdsp_op_t op_nxt;
	logic rst_meta_r;
	logic rst_sync_r;
	logic rvalid_r;
	logic rvalid_nxt;
	logic take;
	logic cap_load;

	initial begin
		if (ADDR_W != CDSP_ADDR_W) $error("cdsp_port: address width fixed at 15");
		if (DATA_W != CDSP_DATA_W) $error("cdsp_port: data width fixed at 16");
		if (CDSP_CYCLE_CLKS != 2) $error("cdsp_port: sequencer built for two clocks");
	end

	// lane selects for an access, inactive lanes stay high
	function automatic logic [CDSP_LANES-1:0] lane_sel_n(input cdsp_op_t op, input logic [CDSP_LANES-1:0] lanes);
		lane_sel_n = (op == CDSP_OP_IDLE) ? ~CDSP_LANES_OFF : ~lanes;
	endfunction : lane_sel_n

	// reset release through two flops
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	// new request is accepted at the end of idle or of a strobe clock
	assign take = i_req_valid && (i_req.op != CDSP_OP_IDLE) && (state_r != CDSP_ST_SETUP);
	assign o_req_ready = take;

	// sequencer and pin next values
	always_comb begin
		state_nxt = state_r;
		op_nxt = op_r;
		pins_nxt = pins_r;
		rvalid_nxt = 1'b0;
		unique case (state_r)
			CDSP_ST_IDLE, CDSP_ST_STROBE: begin
				if (take) begin
					// first clock: address, selects and write data, no strobe
					state_nxt = CDSP_ST_SETUP;
					op_nxt = i_req.op;
					pins_nxt.cache_word_addr = i_req.addr;
					{pins_nxt.upper_lane_select_n, pins_nxt.lower_lane_select_n} =
						lane_sel_n(i_req.op, i_req.lanes);
					pins_nxt.ram_write_strobe_n = 1'b1;
					pins_nxt.ram_output_enable_n = 1'b1;
					pins_nxt.data_out = i_req.wdata;
					pins_nxt.data_oe = (i_req.op == CDSP_OP_WRITE);
				end else begin
					// idle: controls inactive, address held
					state_nxt = CDSP_ST_IDLE;
					op_nxt = CDSP_OP_IDLE;
					pins_nxt.upper_lane_select_n = 1'b1;
					pins_nxt.lower_lane_select_n = 1'b1;
					pins_nxt.ram_write_strobe_n = 1'b1;
					pins_nxt.ram_output_enable_n = 1'b1;
					pins_nxt.data_oe = 1'b0;
				end
			end
			CDSP_ST_SETUP: begin
				// second clock: one strobe, never both
				state_nxt = CDSP_ST_STROBE;
				pins_nxt.ram_write_strobe_n = (op_r != CDSP_OP_WRITE);
				pins_nxt.ram_output_enable_n = (op_r != CDSP_OP_READ);
			end
		endcase
		if (state_r == CDSP_ST_STROBE && op_r == CDSP_OP_READ) begin
			rvalid_nxt = 1'b1;
		end
	end

	// read data is sampled on the edge that ends the output enable pulse
	assign cap_load = (state_r == CDSP_ST_STROBE) && (op_r == CDSP_OP_READ);

	// register the sequencer and pins
	always_ff @(posedge i_clk or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			state_r <= CDSP_ST_IDLE;
			op_r <= CDSP_OP_IDLE;
			rvalid_r <= 1'b0;
			pins_r.cache_word_addr <= CDSP_ADDR_RST;
			pins_r.upper_lane_select_n <= 1'b1;
			pins_r.lower_lane_select_n <= 1'b1;
			pins_r.ram_write_strobe_n <= 1'b1;
			pins_r.ram_output_enable_n <= 1'b1;
			pins_r.data_out <= CDSP_DATA_RST;
			pins_r.data_oe <= 1'b0;
		end else begin
			state_r <= state_nxt;
			op_r <= op_nxt;
			rvalid_r <= rvalid_nxt;
			pins_r <= pins_nxt;
		end
	end

	// read data capture register
	cdsp_rd_latch #(
		.WIDTH(DATA_W)
	) u_rd_latch (
		.i_clk(i_clk),
		.i_rst_n(rst_sync_r),
		.i_load(cap_load),
		.i_data(i_cache_data_bus),
		.o_data(o_rdata)
	);

	// pins straight from flops
	assign o_rdata_valid = rvalid_r;
	assign o_cache_word_addr = pins_r.cache_word_addr;
	assign o_upper_lane_select_n = pins_r.upper_lane_select_n;
	assign o_lower_lane_select_n = pins_r.lower_lane_select_n;
	assign o_ram_write_strobe_n = pins_r.ram_write_strobe_n;
	assign o_ram_output_enable_n = pins_r.ram_output_enable_n;
	assign o_cache_data_bus = pins_r.data_out;
	assign o_cache_data_bus_oe = pins_r.data_oe;
	assign o_copro_addr2 = pins_r.cache_word_addr[CDSP_COPRO_BIT - CDSP_ADDR_LO];
endmodule : cdsp_port

// *** inc/cdsp_pkg.sv ***
// cdsp_pkg: shared constants and types for the cache data ram port
// assumes a single 10 MHz system clock domain
package cdsp_pkg;
	localparam int CDSP_ADDR_HI = 15; // top word address bit
	localparam int CDSP_ADDR_LO = 1; // no byte bit, ram is two bytes wide
	localparam int CDSP_ADDR_W = CDSP_ADDR_HI - CDSP_ADDR_LO + 1;
	localparam int CDSP_DATA_W = 16;
	localparam int CDSP_LANES = 2;
	localparam int CDSP_COPRO_BIT = 2; // address bit also sent to coprocessor
	localparam int CDSP_CLK_PERIOD_NS = 100;
	localparam int CDSP_CS_LEAD_NS = 1; // selects lead output enable by this much
	// least time, rounded up, never below one cycle
	localparam int CDSP_CS_LEAD_CYC = (CDSP_CS_LEAD_NS + CDSP_CLK_PERIOD_NS - 1) / CDSP_CLK_PERIOD_NS < 1 ? 1 :
		(CDSP_CS_LEAD_NS + CDSP_CLK_PERIOD_NS - 1) / CDSP_CLK_PERIOD_NS;
	localparam int CDSP_CYCLE_CLKS = 2; // one ram cycle spans two clocks
	localparam logic [CDSP_ADDR_W-1:0] CDSP_ADDR_RST = 15'h0000;
	localparam logic [CDSP_DATA_W-1:0] CDSP_DATA_RST = 16'h0000;
	localparam logic [CDSP_LANES-1:0] CDSP_LANES_OFF = 2'h0;

	typedef enum logic [1:0] {
		CDSP_OP_IDLE,
		CDSP_OP_READ,
		CDSP_OP_WRITE
	} cdsp_op_t;

	// request from the cache controller
	typedef struct packed {
		cdsp_op_t op;
		logic [CDSP_ADDR_W-1:0] addr;
		logic [CDSP_LANES-1:0] lanes; // bit1 upper byte, bit0 lower byte
		logic [CDSP_DATA_W-1:0] wdata;
	} cdsp_req_t;

	// pins toward the static rams
	typedef struct packed {
		logic [CDSP_ADDR_W-1:0] cache_word_addr;
		logic upper_lane_select_n;
		logic lower_lane_select_n;
		logic ram_write_strobe_n;
		logic ram_output_enable_n;
		logic [CDSP_DATA_W-1:0] data_out;
		logic data_oe;
	} cdsp_pins_t;
endpackage : cdsp_pkg

// *** hdl/cdsp_rd_latch.sv ***
// cdsp_rd_latch: captures read data from the ram bus into a register
// assumes load is a one-cycle pulse in the clock domain of i_clk
`timescale 1ns/1ps
module cdsp_rd_latch
	import cdsp_pkg::*;
#(
	parameter int WIDTH = CDSP_DATA_W
) (
	input wire logic i_clk, // system clock
	input wire logic i_rst_n, // synchronised reset, active low
	input wire logic i_load, // capture strobe
	input wire logic [WIDTH-1:0] i_data, // bus value
	output logic [WIDTH-1:0] o_data // held value
);
	logic [WIDTH-1:0] data_r;
	logic [WIDTH-1:0] data_nxt;

	initial begin
		if (WIDTH < 1) $error("cdsp_rd_latch: width must be positive");
	end

	// hold unless loading
	always_comb begin
		data_nxt = i_load ? i_data : data_r;
	end

	// register stage
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			data_r <= '0;
		end else begin
			data_r <= data_nxt;
		end
	end

	assign o_data = data_r;
endmodule : cdsp_rd_latch

// *** dv/cdsp_port_sva.sv ***
// cdsp_port_sva: pin timing checks on the cache data ram port
// assumes it is bound onto cdsp_port, with one clock domain
`timescale 1ns/1ps
module cdsp_port_sva
	import cdsp_pkg::*;
(
	input wire logic i_clk, // clock
	input wire logic i_reset_n, // reset, active low
	input wire cdsp_req_t i_req, // request
	input wire logic i_req_valid, // request present
	input wire logic o_req_ready, // request taken
	input wire logic o_rdata_valid, // read done
	input wire logic [CDSP_ADDR_W-1:0] o_cache_word_addr, // address
	input wire logic o_upper_lane_select_n, // upper select
	input wire logic o_lower_lane_select_n, // lower select
	input wire logic o_ram_write_strobe_n, // write strobe
	input wire logic o_ram_output_enable_n, // output enable
	input wire logic o_cache_data_bus_oe, // bus drive
	input wire logic o_copro_addr2 // coprocessor bit
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	logic tk;
	logic [1:0] sel;
	logic we;
	logic oe;
	// taken request and short names for the pins
	assign tk = o_req_ready & i_req_valid;
	assign sel = {o_upper_lane_select_n, o_lower_lane_select_n};
	assign we = o_ram_write_strobe_n;
	assign oe = o_ram_output_enable_n;
	strobe_excl_a: assert property (we | oe)
		else $error("write strobe and output enable low together");
	read_nodrive_a: assert property (!oe |-> !o_cache_data_bus_oe)
		else $error("bus driven during read");
	read_seq_a: assert property (tk && i_req.op == CDSP_OP_READ |=> oe && sel == ~$past(i_req.lanes)
		##1 !oe ##1 oe && o_rdata_valid) else $error("read cycle out of order");
	write_seq_a: assert property (tk && i_req.op == CDSP_OP_WRITE |=> o_cache_data_bus_oe
		&& sel == ~$past(i_req.lanes) ##1 !we && o_cache_data_bus_oe ##1 we) else $error("write cycle out of order");
	pulse_one_a: assert property ($fell(we) || $fell(oe) |=> we && oe)
		else $error("strobe longer than one clock");
	two_clock_a: assert property (tk |=> !o_req_ready)
		else $error("request taken one clock after another");
	sel_release_a: assert property (($rose(we) || $rose(oe)) && !$past(tk) |-> sel == 2'h3)
		else $error("select held after last cycle");
	addr_hold_a: assert property (!$past(tk) |-> $stable(o_cache_word_addr))
		else $error("address moved without a request");
	copro_bit_a: assert property (o_copro_addr2 == o_cache_word_addr[1])
		else $error("coprocessor bit differs from address");
	cover property (tk && i_req.op == CDSP_OP_READ);
	cover property (tk && i_req.op == CDSP_OP_WRITE);
	cover property (tk ##2 tk);
endmodule : cdsp_port_sva
bind cdsp_port cdsp_port_sva u_sva (.*);

// *** dv/cdsp_sram_pair.sv ***
// cdsp_sram_pair: two byte-wide asynchronous static rams on the data bus
// assumes pins wired straight from the port; only address bits 7..0 decoded
`timescale 1ns/1ps
module cdsp_sram_pair
	import cdsp_pkg::*;
#(
	parameter int P_DLY = 36 // access time, 0 answers at once
) (
	input wire logic [CDSP_ADDR_W-1:0] i_addr, // word address
	input wire logic i_hi_n, // upper byte select
	input wire logic i_lo_n, // lower byte select
	input wire logic i_we_n, // write strobe
	input wire logic i_oe_n, // output enable
	input wire logic [CDSP_DATA_W-1:0] i_wd, // bus level
	output logic [CDSP_DATA_W-1:0] o_rd // value put on bus
);
	logic [15:0] mem [256];
	logic [15:0] last = 16'h0000;
	logic [15:0] rv;
	// store selected bytes once data has settled under the strobe
	always @(negedge i_we_n) begin
		#1;
		if (!i_hi_n) mem[i_addr[7:0]][15:8] = i_wd[15:8];
		if (!i_lo_n) mem[i_addr[7:0]][7:0] = i_wd[7:0];
	end
	// released or unselected bytes show the inverse of the last value
	assign rv = mem[i_addr[7:0]];
	assign #(P_DLY) o_rd = i_oe_n ? ~last : {i_hi_n ? ~last[15:8] : rv[15:8], i_lo_n ? ~last[7:0] : rv[7:0]};
	always @(posedge i_oe_n) last <= o_rd;
endmodule : cdsp_sram_pair

// *** dv/testbench.sv ***
// testbench: random writes and read-backs through the cache ram port
// assumes cdsp_pkg, the port, its checker and the ram model are compiled first
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; $display("BAD %0t %h %h", $time, g, e); end end
module testbench;
	import cdsp_pkg::*;
	logic i_clk = 1'b0;
	logic i_reset_n = 1'b0;
	cdsp_req_t req = '0;
	logic vld = 1'b0;
	logic rdy, rvld, we_n, oe_n, hi_n, lo_n, boe, c2;
	logic [15:0] rdata, dout, rin, bus, ex;
	logic [14:0] addr;
	logic [15:0] shadow [256];
	logic [15:0] q [$];
	logic [31:0] rs = 32'h00016F43;
	int n_mismatch = 0;
	int tests_run = 0;
	always #50 i_clk = ~i_clk;
	// bus level from whichever side drives
	assign bus = boe ? dout : rin;
	cdsp_port dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_req(req), .i_req_valid(vld), .o_req_ready(rdy),
		.o_rdata(rdata), .o_rdata_valid(rvld), .o_cache_word_addr(addr), .o_upper_lane_select_n(hi_n),
		.o_lower_lane_select_n(lo_n), .o_ram_write_strobe_n(we_n), .o_ram_output_enable_n(oe_n),
		.o_cache_data_bus(dout), .o_cache_data_bus_oe(boe), .i_cache_data_bus(bus), .o_copro_addr2(c2));
	cdsp_sram_pair ram (.i_addr(addr), .i_hi_n(hi_n), .i_lo_n(lo_n), .i_we_n(we_n), .i_oe_n(oe_n), .i_wd(bus),
		.o_rd(rin));
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	task finish_test;
		$display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : finish_test
	// one access, held until taken; notes expected read data
	task automatic acc(input cdsp_op_t op, input logic [14:0] a, input logic [1:0] ln, input logic [15:0] d);
		int k;
		@(negedge i_clk);
		req = '{op, a, ln, d};
		vld = 1'b1;
		#1;
		for (k = 0; k < 4 && rdy !== 1'b1; k++) begin
			@(negedge i_clk);
			#1;
		end
		if (rdy !== 1'b1) begin
			n_mismatch++;
			finish_test();
		end
		if (op == CDSP_OP_WRITE) begin
			if (ln[1]) shadow[a[7:0]][15:8] = d[15:8];
			if (ln[0]) shadow[a[7:0]][7:0] = d[7:0];
		end else
			q.push_back(shadow[a[7:0]]);
		@(posedge i_clk);
	endtask : acc
	// compare read data as it appears
	always @(negedge i_clk) if (rvld === 1'b1) begin
		ex = q.pop_front();
		`CHK(rdata, ex)
	end
	initial begin
		int i;
		logic [14:0] a;
		repeat (3) @(negedge i_clk);
		i_reset_n = 1'b1;
		repeat (2) @(negedge i_clk);
		// random write then read back, back to back
		for (i = 0; i < 8; i++) begin
			rs = xs(rs);
			a = rs[14:0];
			acc(CDSP_OP_WRITE, a, 2'h3, rs[31:16]);
			acc(CDSP_OP_READ, a, 2'h3, 16'h0000);
		end
		$display("test write and read done");
		// one lane written, other byte kept
		acc(CDSP_OP_WRITE, a, 2'h1, 16'hA5C3);
		acc(CDSP_OP_READ, a, 2'h3, 16'h0000);
		acc(CDSP_OP_WRITE, a, 2'h2, 16'h3C5A);
		acc(CDSP_OP_READ, a, 2'h3, 16'h0000);
		$display("test byte lanes done");
		// idle: address held, controls inactive, bus released
		@(negedge i_clk) vld = 1'b0;
		repeat (6) @(negedge i_clk);
		`CHK({addr, hi_n, lo_n, we_n, oe_n, boe}, {a, 5'h1E})
		`CHK(c2, a[1])
		`CHK(q.size(), 0)
		$display("test idle done");
		finish_test();
	end
endmodule : testbench
